/* rtl/clk_switch_pkg.sv */
// Purpose: Shared constants for the CPU clock source switch
// Assumes: Wishbone byte addresses, 8-bit registers in the low byte lane
// Notes: Source indices also select the bit of the filtered clock vector
package clk_switch_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_OSC_MODE = 5'h00;
    localparam logic [4:0] OFS_MAIN_OSC = 5'h04;
    localparam logic [4:0] OFS_MAIN_MODE = 5'h08;
    localparam logic [4:0] OFS_PROC_CLK = 5'h0C;
    localparam logic [4:0] OFS_INT_OSC = 5'h10;
    // clock_op_mode_reg fields
    localparam int B_EXT_MAIN = 7;
    localparam int B_MAIN_OSC_SEL = 6;
    localparam int B_EXT_SUB = 5;
    localparam int B_SUB_OSC_SEL = 4;
    localparam int B_AMP = 0;
    // main_osc_ctrl_reg field
    localparam int B_MAIN_HALT = 7;
    // main_clock_mode_reg fields
    localparam int B_HS_PERMIT = 2;
    localparam int B_MAIN_STATUS = 1;
    localparam int B_MAIN_SELECT = 0;
    // processor_clock_ctrl_reg fields
    localparam int B_SUB_START = 6;
    localparam int B_CPU_STATUS = 5;
    localparam int B_CPU_SELECT = 4;
    // internal oscillator mode register field
    localparam int B_INT_HALT = 0;
    localparam logic RST_MAIN_HALT = 1'h1;
    localparam logic RST_INT_HALT = 1'h0;
    // Clock source indices
    localparam logic [1:0] SRC_INT = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_SUB = 2'h2;
    localparam int NUM_SRC = 3;
    // CPU clock gap after the gain bit is set
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam int AMP_GAP_NS = 5000;
    localparam int AMP_GAP_CYCLES = (AMP_GAP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int GAP_W = 9;
    typedef enum logic [0:0] {ST_RUN, ST_HOLD} mux_state_t;
endpackage : clk_switch_pkg

/* rtl/src_sync_if.sv */
// Purpose: Carries raw oscillator levels and their filtered copies
// Assumes: One bit per clock source
// Notes: Filter side drives clean, user side drives raw
`timescale 1ns/1ps
interface src_sync_if;
    logic [clk_switch_pkg::NUM_SRC-1:0] raw;
    logic [clk_switch_pkg::NUM_SRC-1:0] clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface : src_sync_if

/* rtl/src_filter.sv */
// Purpose: Three-stage synchroniser for each oscillator level
// Assumes: Sources are far slower than sys_clk
// Notes: A level counts once stages two and three agree
`timescale 1ns/1ps
module src_filter (
    input wire logic sys_clk,
    input wire logic rst,
    src_sync_if.filt sync
);
    genvar i;
    generate
        for (i = 0; i < clk_switch_pkg::NUM_SRC; i = i + 1)
        begin : g_src
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic clean_reg;
            wire agree = (s2_reg == s3_reg);
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    s1_reg <= 1'h0;
                    s2_reg <= 1'h0;
                    s3_reg <= 1'h0;
                    clean_reg <= 1'h0;
                end
                else
                begin
                    s1_reg <= sync.raw[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    clean_reg <= agree ? s3_reg : clean_reg;
                end
            end
            assign sync.clean[i] = clean_reg;
        end
    endgenerate
endmodule : src_filter

/* rtl/cpu_clock_source_switch.sv */
// Purpose: CPU clock source selection, oscillator controls, Wishbone registers
// Assumes: Oscillator levels arrive as pins far slower than sys_clk
// Notes: cpu_clk is rebuilt at sys_clk resolution from the chosen source
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps

module cpu_clock_source_switch (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [clk_switch_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic int_osc_in,
    input wire logic main_crystal_in,
    input wire logic sub_crystal_in,
    output logic cpu_clk,
    output logic int_osc_en,
    output logic main_crystal_en,
    output logic main_ext_in_en,
    output logic amp_gain_high,
    output logic sub_crystal_en,
    output logic sub_ext_in_en
);
    src_sync_if sync ();

    src_filter u_filter (
        .sys_clk(sys_clk),
        .rst(rst),
        .sync(sync.filt)
    );

    assign sync.raw = {sub_crystal_in, main_crystal_in, int_osc_in};

    logic ack_reg;
    logic [7:0] rdata_reg;
    logic ext_main_clk_sel_reg;
    logic main_osc_sel_reg;
    logic ext_sub_clk_sel_reg;
    logic sub_osc_sel_reg;
    logic amp_gain_high_reg;
    logic amp_lock_reg;
    logic main_osc_halt_reg;
    logic hs_clock_permit_reg;
    logic permit_lock_reg;
    logic main_src_select_reg;
    logic main_src_status_reg;
    logic sub_xtal_start_reg;
    logic cpu_src_select_reg;
    logic int_osc_halt_reg;
    logic [1:0] cur_sel_reg;
    clk_switch_pkg::mux_state_t state_reg;
    logic [clk_switch_pkg::GAP_W-1:0] gap_cnt_reg;
    localparam logic [clk_switch_pkg::GAP_W-1:0] GAP_LOAD =
        clk_switch_pkg::AMP_GAP_CYCLES[clk_switch_pkg::GAP_W-1:0];
    logic src_prev_reg;
    logic cpu_clk_reg;
    logic [5:0] pin_reg;

    // Bus decode
    wire req = wb_cyc_i && wb_stb_i;
    wire wr = req && wb_we_i && ack_reg && wb_sel_i[0];
    wire [7:0] d = wb_dat_i[7:0];
    wire hit_osc = (wb_adr_i == clk_switch_pkg::OFS_OSC_MODE);
    wire hit_moc = (wb_adr_i == clk_switch_pkg::OFS_MAIN_OSC);
    wire hit_mcm = (wb_adr_i == clk_switch_pkg::OFS_MAIN_MODE);
    wire hit_pcc = (wb_adr_i == clk_switch_pkg::OFS_PROC_CLK);
    wire hit_int = (wb_adr_i == clk_switch_pkg::OFS_INT_OSC);
    wire wr_osc = wr && hit_osc;
    wire wr_moc = wr && hit_moc;
    wire wr_mcm = wr && hit_mcm;
    wire wr_pcc = wr && hit_pcc;
    wire wr_int = wr && hit_int;

    // Source selection
    wire [1:0] main_want = main_src_select_reg ? clk_switch_pkg::SRC_MAIN
                                               : clk_switch_pkg::SRC_INT;
    wire [1:0] want_sel = cpu_src_select_reg ? clk_switch_pkg::SRC_SUB : main_want;
    wire src_now = sync.clean[cur_sel_reg];
    wire src_new = sync.clean[want_sel];
    wire on_sub = (cur_sel_reg == clk_switch_pkg::SRC_SUB);
    wire uses_int = (cur_sel_reg == clk_switch_pkg::SRC_INT)
                    || (want_sel == clk_switch_pkg::SRC_INT);
    wire uses_main = (cur_sel_reg == clk_switch_pkg::SRC_MAIN)
                     || (want_sel == clk_switch_pkg::SRC_MAIN);
    wire uses_sub = on_sub || (want_sel == clk_switch_pkg::SRC_SUB);
    wire commit = (state_reg == clk_switch_pkg::ST_HOLD) && !src_new;
    wire leave = (state_reg == clk_switch_pkg::ST_RUN) && (want_sel != cur_sel_reg)
                 && !src_now && !cpu_clk_reg;
    wire gap_on = (gap_cnt_reg != '0);
    // Gap counts only once the current high has ended, so the low lasts the full gap
    wire gap_tick = gap_on && !cpu_clk_reg;

    // Read mux
    wire [7:0] rd_osc = {ext_main_clk_sel_reg, main_osc_sel_reg, ext_sub_clk_sel_reg,
                         sub_osc_sel_reg, 3'h0, amp_gain_high_reg};
    wire [7:0] rd_moc = {main_osc_halt_reg, 7'h00};
    wire [7:0] rd_mcm = {5'h00, hs_clock_permit_reg, main_src_status_reg,
                         main_src_select_reg};
    wire [7:0] rd_pcc = {1'h0, sub_xtal_start_reg, on_sub, cpu_src_select_reg,
                         4'h0};
    wire [7:0] rd_int = {7'h00, int_osc_halt_reg};
    wire [7:0] rdata_next = hit_osc ? rd_osc :
                            hit_moc ? rd_moc :
                            hit_mcm ? rd_mcm :
                            hit_pcc ? rd_pcc :
                            hit_int ? rd_int : 8'h00;

    // One-change-only fields
    wire amp_change = wr_osc && !amp_lock_reg
                      && (d[clk_switch_pkg::B_AMP] != amp_gain_high_reg);
    wire permit_change = wr_mcm && !permit_lock_reg
                         && (d[clk_switch_pkg::B_HS_PERMIT] != hs_clock_permit_reg);
    wire amp_set = amp_change && d[clk_switch_pkg::B_AMP];

    // Halts only reach a source the CPU neither uses nor is heading for
    wire int_halt_next = wr_int ? (d[clk_switch_pkg::B_INT_HALT] && !uses_int)
                                  || (int_osc_halt_reg && uses_int)
                                : int_osc_halt_reg;
    wire main_halt_next = wr_moc ? (d[clk_switch_pkg::B_MAIN_HALT] && !uses_main)
                                   || (main_osc_halt_reg && uses_main)
                                 : main_osc_halt_reg;
    wire sub_sel_next = wr_osc ? d[clk_switch_pkg::B_SUB_OSC_SEL]
                                 || (sub_osc_sel_reg && uses_sub)
                               : sub_osc_sel_reg;
    wire main_select_next = wr_mcm ? d[clk_switch_pkg::B_MAIN_SELECT]
                                     && (hs_clock_permit_reg || main_src_select_reg)
                                   : main_src_select_reg;
    wire status_next = commit ? (want_sel == clk_switch_pkg::SRC_MAIN) :
                       (on_sub && state_reg == clk_switch_pkg::ST_RUN) ?
                       main_src_select_reg : main_src_status_reg;

    // Clock rebuild: rise only on a fresh source edge, fall only with the source
    wire clk_next = (state_reg == clk_switch_pkg::ST_HOLD) ? 1'h0 :
                    gap_on ? (cpu_clk_reg && src_now) :
                    (src_now && (cpu_clk_reg || !src_prev_reg));
    wire [5:0] pin_next = {!sub_osc_sel_reg ? 1'h0 : ext_sub_clk_sel_reg,
                           (sub_osc_sel_reg && !ext_sub_clk_sel_reg) || sub_xtal_start_reg,
                           main_osc_sel_reg && ext_main_clk_sel_reg && !main_osc_halt_reg,
                           main_osc_sel_reg && !ext_main_clk_sel_reg && !main_osc_halt_reg,
                           amp_gain_high_reg,
                           !int_osc_halt_reg};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ack_reg <= 1'h0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            ack_reg <= req && !ack_reg;
            rdata_reg <= (req && !ack_reg) ? rdata_next : rdata_reg;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ext_main_clk_sel_reg <= 1'h0;
            main_osc_sel_reg <= 1'h0;
            ext_sub_clk_sel_reg <= 1'h0;
            sub_osc_sel_reg <= 1'h0;
            amp_gain_high_reg <= 1'h0;
            amp_lock_reg <= 1'h0;
            main_osc_halt_reg <= clk_switch_pkg::RST_MAIN_HALT;
            int_osc_halt_reg <= clk_switch_pkg::RST_INT_HALT;
        end
        else
        begin
            ext_main_clk_sel_reg <= wr_osc ? d[clk_switch_pkg::B_EXT_MAIN]
                                           : ext_main_clk_sel_reg;
            main_osc_sel_reg <= wr_osc ? d[clk_switch_pkg::B_MAIN_OSC_SEL]
                                       : main_osc_sel_reg;
            ext_sub_clk_sel_reg <= wr_osc ? d[clk_switch_pkg::B_EXT_SUB]
                                          : ext_sub_clk_sel_reg;
            sub_osc_sel_reg <= sub_sel_next;
            amp_gain_high_reg <= amp_change ? d[clk_switch_pkg::B_AMP]
                                            : amp_gain_high_reg;
            amp_lock_reg <= amp_lock_reg || amp_change;
            main_osc_halt_reg <= main_halt_next;
            int_osc_halt_reg <= int_halt_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            hs_clock_permit_reg <= 1'h0;
            permit_lock_reg <= 1'h0;
            main_src_select_reg <= 1'h0;
            main_src_status_reg <= 1'h0;
            sub_xtal_start_reg <= 1'h0;
            cpu_src_select_reg <= 1'h0;
        end
        else
        begin
            hs_clock_permit_reg <= permit_change ? d[clk_switch_pkg::B_HS_PERMIT]
                                                 : hs_clock_permit_reg;
            permit_lock_reg <= permit_lock_reg || permit_change;
            main_src_select_reg <= main_select_next;
            main_src_status_reg <= status_next;
            sub_xtal_start_reg <= wr_pcc ? d[clk_switch_pkg::B_SUB_START]
                                         : sub_xtal_start_reg;
            cpu_src_select_reg <= wr_pcc ? d[clk_switch_pkg::B_CPU_SELECT]
                                         : cpu_src_select_reg;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= clk_switch_pkg::ST_RUN;
            cur_sel_reg <= clk_switch_pkg::SRC_INT;
        end
        else
        begin
            case (state_reg)
                clk_switch_pkg::ST_RUN:
                begin
                    state_reg <= leave ? clk_switch_pkg::ST_HOLD : clk_switch_pkg::ST_RUN;
                end
                clk_switch_pkg::ST_HOLD:
                begin
                    state_reg <= commit ? clk_switch_pkg::ST_RUN : clk_switch_pkg::ST_HOLD;
                    cur_sel_reg <= commit ? want_sel : cur_sel_reg;
                end
                default:
                begin
                    state_reg <= clk_switch_pkg::ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            gap_cnt_reg <= '0;
            src_prev_reg <= 1'h0;
            cpu_clk_reg <= 1'h0;
            pin_reg <= 6'h00;
        end
        else
        begin
            gap_cnt_reg <= amp_set ? GAP_LOAD :
                           gap_tick ? gap_cnt_reg - 1'b1 : gap_cnt_reg;
            src_prev_reg <= commit ? 1'h0 : src_now;
            cpu_clk_reg <= clk_next;
            pin_reg <= pin_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = {24'h000000, rdata_reg};
    assign cpu_clk = cpu_clk_reg;
    assign {sub_ext_in_en, sub_crystal_en, main_ext_in_en, main_crystal_en,
            amp_gain_high, int_osc_en} = pin_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_read(logic [4:0] ofs);
        req && !wb_we_i && !ack_reg && (wb_adr_i == ofs) ##1 ack_reg;
    endsequence

    a_osc_bits_read: assert property (s_read(clk_switch_pkg::OFS_OSC_MODE) |->
        wb_dat_o[7:0] == {ext_main_clk_sel_reg, main_osc_sel_reg, ext_sub_clk_sel_reg,
                          sub_osc_sel_reg, 3'h0, amp_gain_high_reg})
        else $error("operation mode bits read back misplaced");
    a_halt_bit_read: assert property (s_read(clk_switch_pkg::OFS_MAIN_OSC) |->
        wb_dat_o[7:0] == {main_osc_halt_reg, 7'h00})
        else $error("main halt bit read back misplaced");
    a_mode_bits_read: assert property (s_read(clk_switch_pkg::OFS_MAIN_MODE) |->
        wb_dat_o[2] == hs_clock_permit_reg && wb_dat_o[0] == main_src_select_reg)
        else $error("main mode bits read back misplaced");
    a_cpu_sel_read: assert property (s_read(clk_switch_pkg::OFS_PROC_CLK) |->
        wb_dat_o[4] == cpu_src_select_reg)
        else $error("cpu select bit read back misplaced");
    a_status_read: assert property (s_read(clk_switch_pkg::OFS_MAIN_MODE) |->
        wb_dat_o[1] == $past(main_src_status_reg))
        else $error("main status bit read back wrong");
    a_gap_load_hold: assert property (amp_set |=> gap_cnt_reg == GAP_LOAD
        ##1 (!cpu_clk_reg || $past(cpu_clk_reg))[*8])
        else $error("gain gap not loaded or clock restarted");
    a_gap_clk_low: assert property (gap_on && !cpu_clk_reg |=> !cpu_clk_reg)
        else $error("cpu clock rose during gain gap");
    a_int_halt_guard: assert property ($rose(int_osc_halt_reg) |->
        $past(cur_sel_reg) != clk_switch_pkg::SRC_INT)
        else $error("internal oscillator halted while in use");
    a_main_halt_guard: assert property ($rose(main_osc_halt_reg) |->
        $past(cur_sel_reg) != clk_switch_pkg::SRC_MAIN)
        else $error("main source halted while in use");
    a_sub_stop_guard: assert property ($fell(sub_osc_sel_reg) |->
        $past(cur_sel_reg) != clk_switch_pkg::SRC_SUB)
        else $error("subsystem source stopped while in use");
    a_once_only: assert property (amp_lock_reg && permit_lock_reg |=>
        $stable(amp_gain_high_reg) && $stable(hs_clock_permit_reg))
        else $error("locked bit changed again");
    a_clean_rise: assert property ($rose(cpu_clk_reg) |->
        !$past(src_prev_reg) && $past(state_reg) == clk_switch_pkg::ST_RUN)
        else $error("cpu clock rose without a fresh source edge");

    sequence s_leave;
        leave;
    endsequence

    a_gap_wait_high: assert property (gap_on && cpu_clk_reg && !amp_set |=>
        gap_cnt_reg == $past(gap_cnt_reg))
        else $error("gain gap counted while cpu clock high");
    a_hold_clk_low: assert property (state_reg == clk_switch_pkg::ST_HOLD |->
        !cpu_clk_reg)
        else $error("cpu clock high during source hold");
    a_leave_quiet: assert property (s_leave |=>
        state_reg == clk_switch_pkg::ST_HOLD && !cpu_clk_reg
        && cur_sel_reg == $past(cur_sel_reg))
        else $error("source change did not start cleanly");
    a_select_permit: assert property ($rose(main_src_select_reg) |->
        $past(hs_clock_permit_reg))
        else $error("main source selected without permit");
    a_main_pins: assert property ({main_ext_in_en, main_crystal_en} ==
        $past({main_osc_sel_reg && ext_main_clk_sel_reg && !main_osc_halt_reg,
               main_osc_sel_reg && !ext_main_clk_sel_reg && !main_osc_halt_reg}))
        else $error("main source enables wrong");
    a_sub_pins: assert property (sub_ext_in_en ==
        $past(sub_osc_sel_reg && ext_sub_clk_sel_reg))
        else $error("subsystem input enable wrong");
endmodule : cpu_clock_source_switch

/* dv/test_cpu_clock_source_switch.sv */
// Purpose: Self-checking bench for the CPU clock source switch
// Assumes: Oscillator levels are modelled as slow toggles that run only while enabled
// Notes: Read results are checked against a queue of notes by a monitor process
`timescale 1ns/1ps
module test_cpu_clock_source_switch;
    typedef struct packed {logic [31:0] v; logic [31:0] m;} note_t;
    localparam int HP[3] = '{7, 5, 13};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [clk_switch_pkg::ADDR_W-1:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, cpu_clk, int_osc_en, main_crystal_en, main_ext_in_en;
    logic amp_gain_high, sub_crystal_en, sub_ext_in_en;
    logic [2:0] osc = 3'h0;
    logic [2:0] run;
    logic [31:0] rq;
    int oc[3] = '{0, 0, 0};
    int bad_count = 0;
    int n_checks = 0;
    int high_run = 0;
    int low_run = 0;
    int max_low = 0;
    note_t exp_q[$];
    note_t nt;

    cpu_clock_source_switch dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .int_osc_in(osc[0]), .main_crystal_in(osc[1]), .sub_crystal_in(osc[2]),
        .cpu_clk(cpu_clk), .int_osc_en(int_osc_en), .main_crystal_en(main_crystal_en),
        .main_ext_in_en(main_ext_in_en), .amp_gain_high(amp_gain_high),
        .sub_crystal_en(sub_crystal_en), .sub_ext_in_en(sub_ext_in_en));

    assign run = {sub_crystal_en | sub_ext_in_en, main_crystal_en | main_ext_in_en, int_osc_en};

    always #5 sys_clk = ~sys_clk;

    // A stopped source holds its level
    always @(posedge sys_clk)
    begin
        for (int i = 0; i < 3; i++)
            if (run[i] === 1'b1)
            begin
                if (oc[i] >= HP[i] - 1)
                begin
                    oc[i] <= 0;
                    osc[i] <= ~osc[i];
                end
                else
                    oc[i] <= oc[i] + 1;
            end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic lvl(input logic got, input logic exp);
        cmp({31'h0, got}, {31'h0, exp});
    endtask : lvl

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // Pulse widths of the rebuilt clock and the longest low stretch
    always @(posedge sys_clk)
    begin
        if (rst === 1'b0)
        begin
            if (cpu_clk === 1'b1)
            begin
                high_run <= high_run + 1;
                low_run <= 0;
            end
            else
            begin
                if (high_run > 0)
                    cmp({31'h0, high_run >= 4}, 32'h1);
                high_run <= 0;
                low_run <= low_run + 1;
                if (low_run + 1 > max_low)
                    max_low <= low_run + 1;
            end
        end
    end

    always @(posedge sys_clk)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
        begin
            nt = exp_q.pop_front();
            if (nt.m != 32'h0)
                cmp(wb_dat_o & nt.m, nt.v);
        end
    end

    task automatic xfer(input logic we, input logic [4:0] adr, input logic [7:0] d,
                        input logic [3:0] sel, output logic [31:0] q);
        int n;
        logic [31:0] r;
        r = $urandom;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {r[31:8], d};
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            bad_count++;
            $display("bus answer missing at %0t", $time);
            close_out();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask : xfer

    task automatic wr(input logic [4:0] adr, input logic [7:0] d);
        xfer(1'b1, adr, d, 4'hF, rq);
    endtask : wr

    task automatic rd(input logic [4:0] adr, input logic [7:0] v);
        exp_q.push_back('{v: {24'h0, v}, m: 32'hFFFFFFFF});
        xfer(1'b0, adr, 8'h00, 4'hF, rq);
    endtask : rd

    task automatic poll(input logic [4:0] adr, input int b, input logic val);
        int k;
        for (k = 0; k < 300; k++)
        begin
            exp_q.push_back('{v: 32'h0, m: 32'h0});
            xfer(1'b0, adr, 8'h00, 4'hF, rq);
            if (rq[b] === val)
                break;
        end
        if (k == 300)
        begin
            bad_count++;
            $display("status never changed at %0t", $time);
        end
    endtask : poll

    task automatic settle;
        repeat (2) @(posedge sys_clk);
    endtask : settle

    initial
    begin
        #(60000 * 10);
        bad_count++;
        $display("watchdog expired");
        close_out();
    end

    initial
    begin
        void'($urandom(97094));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (30) @(posedge sys_clk);
        rd(clk_switch_pkg::OFS_MAIN_OSC, 8'h80);
        rd(clk_switch_pkg::OFS_OSC_MODE, 8'h00);
        rd(clk_switch_pkg::OFS_MAIN_MODE, 8'h00);
        rd(clk_switch_pkg::OFS_PROC_CLK, 8'h00);
        rd(5'h14, 8'h00);
        wr(clk_switch_pkg::OFS_INT_OSC, 8'h01);
        rd(clk_switch_pkg::OFS_INT_OSC, 8'h00);
        lvl(int_osc_en, 1'b1);
        $display("reset test done");
        wr(clk_switch_pkg::OFS_OSC_MODE, 8'h40);
        rd(clk_switch_pkg::OFS_OSC_MODE, 8'h40);
        wr(clk_switch_pkg::OFS_MAIN_OSC, 8'h00);
        settle();
        lvl(main_crystal_en, 1'b1);
        lvl(main_ext_in_en, 1'b0);
        wr(clk_switch_pkg::OFS_MAIN_MODE, 8'h01);
        rd(clk_switch_pkg::OFS_MAIN_MODE, 8'h00);
        wr(clk_switch_pkg::OFS_MAIN_MODE, 8'h04);
        wr(clk_switch_pkg::OFS_MAIN_MODE, 8'h00);
        rd(clk_switch_pkg::OFS_MAIN_MODE, 8'h04);
        wr(clk_switch_pkg::OFS_MAIN_MODE, 8'h05);
        poll(clk_switch_pkg::OFS_MAIN_MODE, clk_switch_pkg::B_MAIN_STATUS, 1'b1);
        rd(clk_switch_pkg::OFS_MAIN_MODE, 8'h07);
        wr(clk_switch_pkg::OFS_INT_OSC, 8'h01);
        settle();
        lvl(int_osc_en, 1'b0);
        $display("main crystal test done");
        max_low = 0;
        wr(clk_switch_pkg::OFS_OSC_MODE, 8'h41);
        settle();
        lvl(amp_gain_high, 1'b1);
        for (int k = 0; k < 3000 && cpu_clk !== 1'b0; k++)
            @(posedge sys_clk);
        for (int k = 0; k < 3000 && cpu_clk !== 1'b1; k++)
            @(posedge sys_clk);
        lvl(cpu_clk, 1'b1);
        cmp({31'h0, max_low >= clk_switch_pkg::AMP_GAP_CYCLES}, 32'h1);
        wr(clk_switch_pkg::OFS_OSC_MODE, 8'h40);
        rd(clk_switch_pkg::OFS_OSC_MODE, 8'h41);
        $display("gain gap test done");
        wr(clk_switch_pkg::OFS_PROC_CLK, 8'h40);
        settle();
        lvl(sub_crystal_en, 1'b1);
        repeat (100) @(posedge sys_clk);
        wr(clk_switch_pkg::OFS_PROC_CLK, 8'h50);
        poll(clk_switch_pkg::OFS_PROC_CLK, clk_switch_pkg::B_CPU_STATUS, 1'b1);
        rd(clk_switch_pkg::OFS_PROC_CLK, 8'h70);
        wr(clk_switch_pkg::OFS_MAIN_OSC, 8'h80);
        settle();
        lvl(main_crystal_en, 1'b0);
        wr(clk_switch_pkg::OFS_INT_OSC, 8'h00);
        wr(clk_switch_pkg::OFS_MAIN_MODE, 8'h04);
        rd(clk_switch_pkg::OFS_MAIN_MODE, 8'h04);
        wr(clk_switch_pkg::OFS_PROC_CLK, 8'h40);
        poll(clk_switch_pkg::OFS_PROC_CLK, clk_switch_pkg::B_CPU_STATUS, 1'b0);
        rd(clk_switch_pkg::OFS_PROC_CLK, 8'h40);
        wr(clk_switch_pkg::OFS_PROC_CLK, 8'h00);
        settle();
        lvl(sub_crystal_en, 1'b0);
        $display("subsystem test done");
        wr(clk_switch_pkg::OFS_OSC_MODE, 8'hC1);
        wr(clk_switch_pkg::OFS_MAIN_OSC, 8'h00);
        settle();
        lvl(main_ext_in_en, 1'b1);
        lvl(main_crystal_en, 1'b0);
        wr(clk_switch_pkg::OFS_MAIN_OSC, 8'h80);
        settle();
        lvl(main_ext_in_en, 1'b0);
        xfer(1'b1, clk_switch_pkg::OFS_OSC_MODE, 8'h00, 4'hE, rq);
        rd(clk_switch_pkg::OFS_OSC_MODE, 8'hC1);
        wr(clk_switch_pkg::OFS_OSC_MODE, 8'hF1);
        settle();
        lvl(sub_ext_in_en, 1'b1);
        $display("external input test done");
        for (int e = 0; e < 2; e++)
        begin
            wr(clk_switch_pkg::OFS_OSC_MODE, {e[0], 7'h71});
            wr(clk_switch_pkg::OFS_PROC_CLK, 8'h10);
            poll(clk_switch_pkg::OFS_PROC_CLK, clk_switch_pkg::B_CPU_STATUS, 1'b1);
            wr(clk_switch_pkg::OFS_OSC_MODE, {e[0], 7'h61});
            rd(clk_switch_pkg::OFS_OSC_MODE, {e[0], 7'h71});
            wr(clk_switch_pkg::OFS_MAIN_OSC, 8'h00);
            repeat (100) @(posedge sys_clk);
            wr(clk_switch_pkg::OFS_MAIN_MODE, 8'h05);
            poll(clk_switch_pkg::OFS_MAIN_MODE, clk_switch_pkg::B_MAIN_STATUS, 1'b1);
            wr(clk_switch_pkg::OFS_PROC_CLK, 8'h00);
            poll(clk_switch_pkg::OFS_PROC_CLK, clk_switch_pkg::B_CPU_STATUS, 1'b0);
            wr(clk_switch_pkg::OFS_OSC_MODE, {e[0], 7'h61});
            settle();
            lvl(sub_ext_in_en, 1'b0);
            wr(clk_switch_pkg::OFS_MAIN_OSC, 8'h80);
            rd(clk_switch_pkg::OFS_MAIN_OSC, 8'h00);
            wr(clk_switch_pkg::OFS_MAIN_MODE, 8'h04);
            poll(clk_switch_pkg::OFS_MAIN_MODE, clk_switch_pkg::B_MAIN_STATUS, 1'b0);
            rd(clk_switch_pkg::OFS_MAIN_MODE, 8'h04);
            $display("return test done");
        end
        close_out();
    end
endmodule : test_cpu_clock_source_switch
